// ==== verilog/cmcc_defines.svh ====
// Constants of the cell monitor command core
`ifndef CMCC_DEFINES_SVH
`define CMCC_DEFINES_SVH
`define CMCC_ADDR_HI        4'h8
`define CMCC_CFG_BYTES      6
`define CMCC_CFG0_RST       8'hE0
`define CMCC_CFGN_RST       8'h00
`define CMCC_CRC_SEED       8'h41
`define CMCC_CRC_POLY       8'h07
`define CMCC_CDC_LSB        0
`define CMCC_CDC_MSB        2
`define CMCC_TOGGLE_POLL    3
`define CMCC_CELL10_BIT     6
`define CMCC_GPIO_LSB       5
`define CMCC_GPIO_MSB       6
`define CMCC_CMD_WRCFG      8'h01
`define CMCC_CMD_RDCFG      8'h02
`define CMCC_CMD_RDCV       8'h04
`define CMCC_CMD_RDFLG      8'h0C
`define CMCC_CMD_RDTMP      8'h0E
`define CMCC_CMD_STCV       8'h10
`define CMCC_CMD_STCV_HOLD  8'h20
`define CMCC_CMD_STTMP      8'h30
`define CMCC_CMD_PLADC      8'h40
`define CMCC_CMD_PLINT      8'h50
`define CMCC_CMD_TEST1      8'h1E
`define CMCC_CMD_TEST2      8'h1F
`define CMCC_CMD_TEST3      8'h2E
`define CMCC_PAT1           12'h555
`define CMCC_PAT2           12'hAAA
`define CMCC_PAT3           12'hFFF
`define CMCC_CONV_NS        13000000
`define CMCC_WDT_NS         2500000000
`define CMCC_CLK_NS         50
`endif

// ==== verilog/cmcc_pkg.sv ====
// Types of the cell monitor command core
`default_nettype none
package cmcc_pkg;
  typedef enum logic [1:0] {
    CMCC_IDLE = 2'b00,
    CMCC_CELL = 2'b01,
    CMCC_TEMP = 2'b10
  } cmcc_conv_t;
endpackage
`default_nettype wire

// ==== verilog/cmcc_sync.sv ====
// Three-stage synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module cmcc_sync #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Level
  input  wire logic d_in,
  output var  logic q_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r  <= INIT;
      s2_r  <= INIT;
      s3_r  <= INIT;
      q_out <= INIT;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_out <= s3_r;
      end
    end
  end
endmodule // cmcc_sync
`default_nettype wire

// ==== verilog/cmcc_core.sv ====
// Command core of an addressable cell monitor
// Functional notes
// - Act, except on poll replies, only when strap address equals low nibble of address byte.
// - Six config bytes; byte zero resets to E0, others to 00.
// - Returned data is followed by a check byte over it.
// - Commands other than polls are discarded without effect when their check byte is bad.
// - Device starts in standby until a config selects another mode.
// - Comparator duty cycle field selects seven modes besides standby.
// - Config changes only on accepted full six-byte write or on a watchdog trip.
// - Config read returns last write, GPIO bits show pin state.
// - Over and under thresholds are programmable quantized config bytes.
// - Three temperature channels: die and two thermistors.
// - Die reading scales at 8 mV per kelvin.
// - Temperatures readable only after a start-temperature conversion ends or a self test command.
// - Cell start converts all twelve cells; read comes later.
// - Per cell over and under flags, read back as three bytes.
// - Per cell mask hides that cell's flags.
// - Discharge bit drives cell discharge after accepted write.
// - Normal cell conversion pauses all discharge during measurement.
// - Hold variant keeps discharge on while measuring.
// - Config holds poll style, GPIO direction, 10/12 cell mode, standby.
// - Poll commands report conversion busy and interrupt on data out.
// - Serial lines held high trip watchdog, config returns to default.
// - Self test loads results with 555, AAA or FFF patterns.
`timescale 1ns/10ps
`default_nettype none
`include "cmcc_defines.svh"
module cmcc_core #(
  parameter int CELLS    = 12,
  parameter int CONV_CYC = (`CMCC_CONV_NS + `CMCC_CLK_NS - 1) / `CMCC_CLK_NS,
  parameter int WDT_CYC  = 50000000
) (
  // System
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic [3:0]        addr_strap_in,
  // Serial link, host clocked
  input  wire logic              link_clk_in,
  input  wire logic              link_sel_n_in,
  input  wire logic              link_mosi_in,
  output var  logic              link_miso_out,
  output var  logic              link_miso_oe_out,
  // Analog front end
  input  wire logic [12*CELLS-1:0] cell_code_in,
  input  wire logic [35:0]       temp_code_in,
  input  wire logic [CELLS-1:0]  cell_over_in,
  input  wire logic [CELLS-1:0]  cell_under_in,
  input  wire logic [1:0]        gpio_pin_in,
  output var  logic [7:0]        over_thresh_out,
  output var  logic [7:0]        under_thresh_out,
  output var  logic [2:0]        comparator_duty_cycle_out,
  output var  logic              standby_out,
  output var  logic              cell10_mode_out,
  output var  logic              toggle_poll_out,
  output var  logic [1:0]        gpio_drive_out,
  output var  logic              conv_busy_out,
  output var  logic [CELLS-1:0]  cell_discharge_control_out
);
  localparam int NB = `CMCC_CFG_BYTES + 3;
  localparam int RB = 3 * CELLS / 2 + 2;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc_step = {c[6:0], 1'b0} ^ (fb ? `CMCC_CRC_POLY : 8'h00);
  endfunction

  // ---------------- Link domain ----------------
  logic [7:0]  sh_r;
  logic [2:0]  bit_r;
  logic [3:0]  byte_r;
  logic [7:0]  rxcrc_r;
  logic [7:0]  rxb_r [NB];
  logic        frame_tog_r;
  logic [3:0]  frame_len_r;
  logic [7:0]  txb;
  logic [7:0]  txcrc_r;
  logic [7:0]  tx_r;
  logic [4:0]  tbyte_r;
  logic        sel_n_l;
  logic [7:0]  rx_byte;
  logic [7:0]  cmd_l;
  logic        is_read;
  logic [7:0]  rdata [RB];
  logic [4:0]  n_data;
  logic        poll_bit;

  assign rx_byte = {sh_r[6:0], link_mosi_in};
  assign cmd_l   = rxb_r[1];
  assign sel_n_l = link_sel_n_in;

  always_ff @(posedge link_clk_in or posedge sel_n_l) begin
    if (sel_n_l) begin
      sh_r    <= 8'h00;
      bit_r   <= 3'h0;
      byte_r  <= 4'h0;
      rxcrc_r <= `CMCC_CRC_SEED;
    end else begin
      sh_r    <= rx_byte;
      bit_r   <= bit_r + 3'h1;
      rxcrc_r <= crc_step(rxcrc_r, link_mosi_in);
      if (bit_r == 3'h7 && byte_r != 4'hF) begin
        byte_r <= byte_r + 4'h1;
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!sel_n_l && bit_r == 3'h7 && byte_r < 4'(NB)) begin
      rxb_r[byte_r] <= rx_byte;
    end
  end

  // Frame end raises a toggle event and keeps the byte count
  always_ff @(posedge sel_n_l or posedge rst_in) begin
    if (rst_in) begin
      frame_tog_r <= 1'b0;
      frame_len_r <= 4'h0;
    end else begin
      frame_tog_r <= ~frame_tog_r;
      frame_len_r <= byte_r;
    end
  end

  // ---------------- Core domain ----------------
  logic [7:0]  cfg_r [`CMCC_CFG_BYTES];
  logic [11:0] cres_r [CELLS];
  logic [11:0] tres_r [3];
  logic [CELLS-1:0] ovf_r;
  logic [CELLS-1:0] uvf_r;
  logic        temp_ok_r;
  cmcc_pkg::cmcc_conv_t conv_r;
  logic        hold_r;
  logic [23:0] conv_cnt_r;
  logic [31:0] wdt_r;
  logic        tog_q;
  logic        tog_d_r;
  logic        mosi_q;
  logic        clk_q;
  logic        sel_q;
  logic        frame_evt;
  logic        addr_ok;
  logic        crc_ok;
  logic        len_ok;
  logic        cmd_ok;
  logic [7:0]  cmd_c;
  logic [1:0]  pat_sel;
  logic [11:0] pat;
  logic [7:0]  crc_chk;
  logic        lines_high;

  cmcc_sync #(.INIT(1'b0)) u_tog  (.clk_in(ref_clk_in), .rst_in(rst_in), .d_in(frame_tog_r),   .q_out(tog_q));
  cmcc_sync #(.INIT(1'b1)) u_mosi (.clk_in(ref_clk_in), .rst_in(rst_in), .d_in(link_mosi_in),  .q_out(mosi_q));
  cmcc_sync #(.INIT(1'b1)) u_clk  (.clk_in(ref_clk_in), .rst_in(rst_in), .d_in(link_clk_in),   .q_out(clk_q));
  cmcc_sync #(.INIT(1'b1)) u_sel  (.clk_in(ref_clk_in), .rst_in(rst_in), .d_in(link_sel_n_in), .q_out(sel_q));

  assign frame_evt = tog_q ^ tog_d_r;
  assign addr_ok = rxb_r[0] == {`CMCC_ADDR_HI, addr_strap_in};
  assign cmd_c   = rxb_r[1];

  // Check over address and command bytes
  assign crc_chk = crc_step_byte(crc_step_byte(`CMCC_CRC_SEED, rxb_r[0]), rxb_r[1]);
  assign crc_ok = crc_chk == rxb_r[2];
  assign len_ok = cmd_c == `CMCC_CMD_WRCFG ? frame_len_r == 4'(NB) : frame_len_r >= 4'h3;
  assign cmd_ok = frame_evt && addr_ok && crc_ok && len_ok;

  assign pat_sel = cmd_c == `CMCC_CMD_TEST1 ? 2'd1 :
                   cmd_c == `CMCC_CMD_TEST2 ? 2'd2 :
                   cmd_c == `CMCC_CMD_TEST3 ? 2'd3 : 2'd0;
  assign pat = pat_sel == 2'd1 ? `CMCC_PAT1 : pat_sel == 2'd2 ? `CMCC_PAT2 : `CMCC_PAT3;
  assign lines_high = mosi_q & clk_q & sel_q;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_d_r <= 1'b0;
    end else begin
      tog_d_r <= tog_q;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wdt_r <= 32'h0;
    end else if (!lines_high || frame_evt) begin
      wdt_r <= 32'h0;
    end else if (wdt_r != 32'(WDT_CYC)) begin
      wdt_r <= wdt_r + 32'h1;
    end
  end

  // store written only on full accepted write or watchdog trip
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r[0] <= `CMCC_CFG0_RST;
      for (int i = 1; i < `CMCC_CFG_BYTES; i++) cfg_r[i] <= `CMCC_CFGN_RST;
    end else if (wdt_r == 32'(WDT_CYC)) begin
      cfg_r[0] <= `CMCC_CFG0_RST;
      for (int i = 1; i < `CMCC_CFG_BYTES; i++) cfg_r[i] <= `CMCC_CFGN_RST;
    end else if (cmd_ok && cmd_c == `CMCC_CMD_WRCFG) begin
      for (int i = 0; i < `CMCC_CFG_BYTES; i++) cfg_r[i] <= rxb_r[i + 3];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_r     <= cmcc_pkg::CMCC_IDLE;
      hold_r     <= 1'b0;
      conv_cnt_r <= 24'h0;
      temp_ok_r  <= 1'b0;
    end else if (conv_r != cmcc_pkg::CMCC_IDLE) begin
      conv_cnt_r <= conv_cnt_r + 24'h1;
      if (conv_cnt_r == 24'(CONV_CYC - 1)) begin
        if (conv_r == cmcc_pkg::CMCC_TEMP) temp_ok_r <= 1'b1;
        conv_r <= cmcc_pkg::CMCC_IDLE;
      end
    end else if (cmd_ok) begin
      conv_cnt_r <= 24'h0;
      hold_r     <= cmd_c == `CMCC_CMD_STCV_HOLD;
      if (cmd_c == `CMCC_CMD_STCV || cmd_c == `CMCC_CMD_STCV_HOLD) conv_r <= cmcc_pkg::CMCC_CELL;
      if (cmd_c == `CMCC_CMD_STTMP) conv_r <= cmcc_pkg::CMCC_TEMP;
      if (pat_sel != 2'd0) temp_ok_r <= 1'b1;
    end
  end

  // Results latched at conversion end; self test loads patterns
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < CELLS; i++) cres_r[i] <= 12'h000;
      for (int i = 0; i < 3; i++) tres_r[i] <= 12'h000;
      ovf_r <= '0;
      uvf_r <= '0;
    end else if (cmd_ok && pat_sel != 2'd0 && conv_r == cmcc_pkg::CMCC_IDLE) begin
      for (int i = 0; i < CELLS; i++) cres_r[i] <= pat;
      for (int i = 0; i < 3; i++) tres_r[i] <= pat;
    end else if (conv_cnt_r == 24'(CONV_CYC - 1) && conv_r == cmcc_pkg::CMCC_CELL) begin
      for (int i = 0; i < CELLS; i++) cres_r[i] <= cell_code_in[12*i +: 12];
      ovf_r <= cell_over_in;
      uvf_r <= cell_under_in;
    end else if (conv_cnt_r == 24'(CONV_CYC - 1) && conv_r == cmcc_pkg::CMCC_TEMP) begin
      // die code passes raw, 8 mV per kelvin
      for (int i = 0; i < 3; i++) tres_r[i] <= temp_code_in[12*i +: 12];
    end
  end

  // ---------------- Config decode ----------------
  // duty cycle field, zero is standby
  assign comparator_duty_cycle_out = cfg_r[0][`CMCC_CDC_MSB:`CMCC_CDC_LSB];
  assign standby_out     = cfg_r[0][`CMCC_CDC_MSB:`CMCC_CDC_LSB] == 3'h0;
  assign toggle_poll_out = cfg_r[0][`CMCC_TOGGLE_POLL];
  assign cell10_mode_out = cfg_r[0][`CMCC_CELL10_BIT - 4];
  assign gpio_drive_out  = cfg_r[0][`CMCC_GPIO_MSB:`CMCC_GPIO_LSB];
  assign under_thresh_out = cfg_r[4];
  assign over_thresh_out  = cfg_r[5];
  assign conv_busy_out   = conv_r != cmcc_pkg::CMCC_IDLE;

  assign cell_discharge_control_out = (conv_r == cmcc_pkg::CMCC_CELL && !hold_r) ? '0 :
                                      {cfg_r[2][3:0], cfg_r[1]};

  // ---------------- Read-back image (link side reads stable data) ----------------
  logic [CELLS-1:0] mask;
  logic [CELLS-1:0] ovm;
  logic [CELLS-1:0] uvm;
  assign mask = {cfg_r[3], cfg_r[2][7:4]};
  assign ovm  = ovf_r & ~mask;
  assign uvm  = uvf_r & ~mask;

  always_comb begin
    for (int i = 0; i < RB; i++) rdata[i] = 8'h00;
    n_data = 5'd0;
    unique case (cmd_l)
      `CMCC_CMD_RDCFG: begin
        for (int i = 0; i < `CMCC_CFG_BYTES; i++) rdata[i] = cfg_r[i];
        rdata[0][`CMCC_GPIO_MSB:`CMCC_GPIO_LSB] = gpio_pin_in;
        n_data = 5'(`CMCC_CFG_BYTES);
      end
      `CMCC_CMD_RDCV: begin
        for (int i = 0; i < CELLS / 2; i++) begin
          rdata[3*i]   = cres_r[2*i][7:0];
          rdata[3*i+1] = {cres_r[2*i+1][3:0], cres_r[2*i][11:8]};
          rdata[3*i+2] = cres_r[2*i+1][11:4];
        end
        n_data = 5'(3 * CELLS / 2);
      end
      `CMCC_CMD_RDFLG: begin
        for (int i = 0; i < CELLS; i++) begin
          rdata[i/4][2*(i%4)]   = uvm[i];
          rdata[i/4][2*(i%4)+1] = ovm[i];
        end
        n_data = 5'd3;
      end
      `CMCC_CMD_RDTMP: begin
        if (temp_ok_r) begin
          rdata[0] = tres_r[0][7:0];
          rdata[1] = {tres_r[1][3:0], tres_r[0][11:8]};
          rdata[2] = tres_r[1][11:4];
          rdata[3] = tres_r[2][7:0];
          rdata[4] = {4'h0, tres_r[2][11:8]};
          n_data = 5'd5;
        end
      end
      default: begin
        n_data = 5'd0;
      end
    endcase
  end

  assign poll_bit = cmd_l == `CMCC_CMD_PLADC ? ~conv_busy_out :
                    cmd_l == `CMCC_CMD_PLINT ? ~(|ovm | |uvm) : 1'b1;
  assign is_read  = addr_ok && crc_ok && n_data != 5'd0;
  assign txb      = tbyte_r < n_data ? rdata[tbyte_r] : txcrc_r;

  // shift out on falling host clock
  always_ff @(negedge link_clk_in or posedge sel_n_l) begin
    if (sel_n_l) begin
      tx_r    <= 8'hFF;
      tbyte_r <= 5'h00;
      txcrc_r <= `CMCC_CRC_SEED;
    end else if (byte_r >= 4'h3 && bit_r == 3'h0) begin
      tx_r <= txb;
      if (tbyte_r < n_data) begin
        txcrc_r <= crc_step_byte(txcrc_r, txb);
      end
      if (tbyte_r != 5'h1F) tbyte_r <= tbyte_r + 5'h01;
    end else begin
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  function automatic logic [7:0] crc_step_byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) r = crc_step(r, d[i]);
    crc_step_byte = r;
  endfunction

  assign link_miso_out    = byte_r >= 4'h3 && is_read ? tx_r[7] : poll_bit;
  assign link_miso_oe_out = ~sel_n_l;
endmodule // cmcc_core
`default_nettype wire

// ==== tb/cmcc_core_monitor.sv ====
// Concurrent checks on the command core ports
`timescale 1ns/10ps
`default_nettype none
module cmcc_core_monitor #(
  parameter int CELLS    = 12,
  parameter int CONV_CYC = 20,
  parameter int WDT_CYC  = 100
) (
  // System
  input wire logic             ref_clk_in,
  input wire logic             rst_in,
  // Link
  input wire logic             link_clk_in,
  input wire logic             link_sel_n_in,
  input wire logic             link_mosi_in,
  input wire logic             link_miso_oe_out,
  // Configuration and status
  input wire logic [7:0]       over_thresh_out,
  input wire logic [7:0]       under_thresh_out,
  input wire logic [2:0]       comparator_duty_cycle_out,
  input wire logic             standby_out,
  input wire logic             toggle_poll_out,
  input wire logic [1:0]       gpio_drive_out,
  input wire logic             conv_busy_out,
  input wire logic [CELLS-1:0] cell_discharge_control_out
);
  logic [5:0]  sel_cnt_r;
  logic [15:0] hi_cnt_r;
  logic [15:0] busy_cnt_r;
  wire  [5:0]  sel_cnt_nxt  = !link_sel_n_in ? 6'h00 : (&sel_cnt_r) ? sel_cnt_r : sel_cnt_r + 6'h01;
  wire         all_hi       = link_sel_n_in & link_clk_in & link_mosi_in;
  wire  [15:0] hi_cnt_nxt   = !all_hi ? 16'h0000 : (&hi_cnt_r) ? hi_cnt_r : hi_cnt_r + 16'h0001;
  wire  [15:0] busy_cnt_nxt = conv_busy_out ? busy_cnt_r + 16'h0001 : 16'h0000;
  wire  [21:0] cfg_w        = {over_thresh_out, under_thresh_out, comparator_duty_cycle_out,
                               toggle_poll_out, gpio_drive_out};
  // During a frame or shortly after it closed
  wire         frame_end    = sel_cnt_r < 6'h20;
  wire         wdog         = hi_cnt_r >= 16'(WDT_CYC - 4);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_cnt_r  <= 6'h3F;
      hi_cnt_r   <= 16'h0000;
      busy_cnt_r <= 16'h0000;
    end else begin
      sel_cnt_r  <= sel_cnt_nxt;
      hi_cnt_r   <= hi_cnt_nxt;
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  AST_RST_DEFAULT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $fell(rst_in) |-> standby_out && cfg_w == 22'h000003 && cell_discharge_control_out == '0 && !conv_busy_out)
    else $error("outputs not at default after reset");
  AST_STANDBY_MODE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    standby_out == (comparator_duty_cycle_out == 3'h0))
    else $error("standby does not follow duty cycle field");
  AST_CFG_ONLY_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $changed(cfg_w) |-> frame_end || wdog)
    else $error("configuration changed outside a frame");
  AST_DISCH_ONLY_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $changed(cell_discharge_control_out) |-> frame_end || wdog || conv_busy_out != $past(conv_busy_out)
      || conv_busy_out != $past(conv_busy_out, 2))
    else $error("discharge changed without cause");
  AST_BUSY_LEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $fell(conv_busy_out) |-> busy_cnt_r >= 16'(CONV_CYC - 2) && busy_cnt_r <= 16'(CONV_CYC + 2))
    else $error("conversion length wrong");
  AST_BUSY_START: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(conv_busy_out) |-> frame_end && sel_cnt_r != 6'h00)
    else $error("conversion started without a frame");
  AST_WDT_DEFAULT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    hi_cnt_r == 16'(WDT_CYC + 16) |-> standby_out && over_thresh_out == 8'h00 && cell_discharge_control_out == '0)
    else $error("watchdog did not restore defaults");
  AST_OE_FRAME: assert property (@(posedge link_clk_in) disable iff (rst_in)
    !link_sel_n_in |-> link_miso_oe_out)
    else $error("data out not driven in frame");
  AST_OE_IDLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    link_sel_n_in [*4] |-> !link_miso_oe_out)
    else $error("data out driven outside frame");
  COV_CONV: cover property (@(posedge ref_clk_in) disable iff (rst_in) $fell(conv_busy_out));
  COV_WDT: cover property (@(posedge ref_clk_in) disable iff (rst_in) hi_cnt_r == 16'(WDT_CYC));
  COV_CFG: cover property (@(posedge ref_clk_in) disable iff (rst_in) $changed(cfg_w) && !standby_out);
endmodule // cmcc_core_monitor
`default_nettype wire

// ==== tb/cmcc_host_model.sv ====
// Host model driving the serial command link
`timescale 1ns/10ps
`default_nettype none
`include "cmcc_defines.svh"
module cmcc_host_model (
  // Link
  output var  logic link_clk_out,
  output var  logic link_sel_n_out,
  output var  logic link_mosi_out,
  input  wire logic link_miso_in
);
  logic [7:0] wr [0:5];
  logic [7:0] rd [0:23];
  initial begin
    link_clk_out = 1'b0;
    link_sel_n_out = 1'b1;
    link_mosi_out = 1'b0;
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ `CMCC_CRC_POLY) : (r << 1);
    return r;
  endfunction
  task automatic shift(input logic b, output logic q);
    link_mosi_out = b;
    #40 link_clk_out = 1'b1;
    q = link_miso_in;
    #40 link_clk_out = 1'b0;
  endtask
  task automatic frame(input logic [7:0] adr, input logic [7:0] cmd, input logic bad, input int nw, input int nr);
    logic [7:0] tx [0:8];
    logic q;
    tx[0] = adr;
    tx[1] = cmd;
    tx[2] = crc8(crc8(`CMCC_CRC_SEED, adr), cmd) ^ {7'h00, bad};
    for (int i = 0; i < nw; i++) tx[3 + i] = wr[i];
    link_sel_n_out = 1'b0;
    #40;
    for (int k = 0; k < 3 + nw; k++) for (int j = 7; j >= 0; j--) shift(tx[k][j], q);
    for (int k = 0; k < nr; k++) for (int j = 7; j >= 0; j--) shift(1'b0, rd[k][j]);
    #40 link_sel_n_out = 1'b1;
    #1500;
  endtask
  task automatic hold_high(input int ns);
    link_clk_out = 1'b1;
    link_mosi_out = 1'b1;
    #(ns) link_clk_out = 1'b0;
    link_mosi_out = 1'b0;
    #1000;
  endtask
endmodule // cmcc_host_model
`default_nettype wire

// ==== tb/cell_monitor_command_core_tb_top.sv ====
// Self-checking bench of the cell monitor command core
`timescale 1ns/10ps
`default_nettype none
`include "cmcc_defines.svh"
module cell_monitor_command_core_tb_top;
  localparam int CELLS = 12;
  localparam int CONV  = 200;
  localparam int WDT   = 100;
  logic                ref_clk_in;
  logic                rst_in;
  logic [3:0]          strap;
  logic [12*CELLS-1:0] cells;
  logic [35:0]         temps;
  logic [CELLS-1:0]    ovr;
  logic [CELLS-1:0]    und;
  logic [1:0]          gpio;
  logic [7:0]          cfg [0:5];
  logic [7:0]          ex [0:17];
  logic [31:0]         lfsr;
  logic [31:0]         v;
  logic [7:0]          tc;
  logic [11:0]         tp;
  logic [11:0]         mk;
  int                  failures;
  int                  comparisons;
  wire                 lclk, lsel_n, lmosi, lmiso, loe, stby, c10, tgl, busy;
  wire [7:0]           ovt, unt;
  wire [2:0]           cdc;
  wire [1:0]           gdrv;
  wire [CELLS-1:0]     dis;
  wire [11:0]          dexp = {cfg[2][3:0], cfg[1]};
  cmcc_core #(.CELLS(CELLS), .CONV_CYC(CONV), .WDT_CYC(WDT)) DUT (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_strap_in(strap), .link_clk_in(lclk),
    .link_sel_n_in(lsel_n), .link_mosi_in(lmosi), .link_miso_out(lmiso), .link_miso_oe_out(loe),
    .cell_code_in(cells), .temp_code_in(temps), .cell_over_in(ovr), .cell_under_in(und),
    .gpio_pin_in(gpio), .over_thresh_out(ovt), .under_thresh_out(unt), .comparator_duty_cycle_out(cdc),
    .standby_out(stby), .cell10_mode_out(c10), .toggle_poll_out(tgl), .gpio_drive_out(gdrv),
    .conv_busy_out(busy), .cell_discharge_control_out(dis));
  cmcc_host_model hm (.link_clk_out(lclk), .link_sel_n_out(lsel_n), .link_mosi_out(lmosi), .link_miso_in(lmiso));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input int n);
    logic [7:0] p;
    p = `CMCC_CRC_SEED;
    for (int k = 0; k < n; k++) begin
      chk(16'(hm.rd[k]), 16'(ex[k]));
      p = hm.crc8(p, ex[k]);
    end
    chk(16'(hm.rd[n]), 16'(p));
  endtask
  task automatic pack(input int i, input logic [11:0] a, input logic [11:0] b);
    ex[i] = a[7:0];
    ex[i + 1] = {b[3:0], a[11:8]};
    ex[i + 2] = b[11:4];
  endtask
  task automatic cmd(input logic [7:0] c, input int nr);
    hm.frame({`CMCC_ADDR_HI, strap}, c, 1'b0, 6 * int'(c == `CMCC_CMD_WRCFG), nr);
  endtask
  task automatic rdcfg;
    for (int i = 0; i < 6; i++) ex[i] = cfg[i];
    ex[0][6:5] = gpio;
    cmd(`CMCC_CMD_RDCFG, 7);
    chk_rd(6);
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 2000) begin
      @(posedge ref_clk_in);
      i++;
    end
    if (i == 2000) begin
      failures++;
      $display("ERROR t=%0t busy got=%h exp=%h", $time, 1'b1, 1'b0);
      end_sim;
    end
  endtask
  task automatic end_sim;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    failures = 0;
    comparisons = 0;
    lfsr = 32'h0001_3445;
    rst_in = 1'b1;
    strap = 4'h0;
    cells = '0;
    temps = '0;
    ovr = '0;
    und = '0;
    gpio = 2'h0;
    repeat (12) @(posedge ref_clk_in);
    #2;
    v = rnd();
    strap = v[3:0];
    gpio = v[5:4];
    ovr = v[17:6];
    und = v[29:18];
    for (int i = 0; i < CELLS; i++) begin
      v = rnd();
      cells[12 * i +: 12] = v[11:0];
    end
    v = rnd();
    temps = {v[3:0], rnd()};
    rst_in = 1'b0;
    repeat (6) @(posedge ref_clk_in);
    #2;
    for (int i = 0; i < 6; i++) cfg[i] = (i == 0) ? `CMCC_CFG0_RST : `CMCC_CFGN_RST;
    rdcfg;
    chk(16'(stby), 16'h0001);
    for (int i = 0; i < 6; i++) hm.wr[i] = 8'hFF;
    hm.frame({`CMCC_ADDR_HI, ~strap}, `CMCC_CMD_WRCFG, 1'b0, 6, 0);
    hm.frame({`CMCC_ADDR_HI, strap}, `CMCC_CMD_WRCFG, 1'b1, 6, 0);
    rdcfg;
    $display("test reset and refusal done");
    for (int m = 0; m < 8; m++) begin
      for (int i = 0; i < 6; i++) begin
        v = rnd();
        cfg[i] = v[7:0];
      end
      cfg[0][2:0] = 3'(m);
      cfg[1][0] = 1'b1;
      cfg[2][7:4] = 4'h0;
      cfg[3] = 8'h00;
      for (int i = 0; i < 6; i++) hm.wr[i] = cfg[i];
      cmd(`CMCC_CMD_WRCFG, 0);
      rdcfg;
      chk(16'(cdc), 16'(m));
      chk(16'(stby), 16'(m == 0));
      chk(16'({ovt, unt}), {cfg[5], cfg[4]});
      chk(16'({c10, tgl, gdrv}), 16'({cfg[0][2], cfg[0][3], cfg[0][6:5]}));
      chk(16'(dis), 16'(dexp));
    end
    $display("test config done");
    cmd(`CMCC_CMD_STCV, 0);
    chk(16'({busy, dis}), 16'h1000);
    cmd(`CMCC_CMD_PLADC, 1);
    chk(16'(hm.rd[0][7]), 16'h0000);
    wait_idle;
    chk(16'(dis), 16'(dexp));
    for (int i = 0; i < 6; i++) pack(3 * i, cells[24 * i +: 12], cells[24 * i + 12 +: 12]);
    cmd(`CMCC_CMD_RDCV, 19);
    chk_rd(18);
    for (int k = 0; k < 12; k++) ex[k / 4][2 * (k % 4) +: 2] = {ovr[k], und[k]};
    cmd(`CMCC_CMD_RDFLG, 4);
    chk_rd(3);
    v = rnd();
    cfg[2][7:4] = v[3:0];
    cfg[3] = v[11:4];
    mk = {cfg[3], cfg[2][7:4]};
    for (int i = 0; i < 6; i++) hm.wr[i] = cfg[i];
    cmd(`CMCC_CMD_WRCFG, 0);
    for (int k = 0; k < 12; k++) ex[k / 4][2 * (k % 4) +: 2] = {ovr[k], und[k]} & {2{~mk[k]}};
    cmd(`CMCC_CMD_RDFLG, 4);
    chk_rd(3);
    cmd(`CMCC_CMD_PLINT, 1);
    chk(16'(hm.rd[0][7]), 16'(~|((ovr | und) & ~mk)));
    cmd(`CMCC_CMD_STCV_HOLD, 0);
    chk(16'({busy, dis}), 16'({1'b1, dexp}));
    wait_idle;
    cmd(`CMCC_CMD_PLADC, 1);
    chk(16'(hm.rd[0][7]), 16'h0001);
    $display("test cell conversion done");
    cmd(`CMCC_CMD_RDTMP, 1);
    chk(16'(hm.rd[0]), 16'h00FF);
    cmd(`CMCC_CMD_STTMP, 0);
    wait_idle;
    pack(0, temps[11:0], temps[23:12]);
    ex[3] = temps[31:24];
    cmd(`CMCC_CMD_RDTMP, 6);
    for (int k = 0; k < 4; k++) chk(16'(hm.rd[k]), 16'(ex[k]));
    chk(16'(hm.rd[4][3:0]), 16'(temps[35:32]));
    ex[4] = 8'(temps[35:32]);
    chk_rd(5);
    for (int t = 0; t < 3; t++) begin
      tc = (t == 0) ? `CMCC_CMD_TEST1 : (t == 1) ? `CMCC_CMD_TEST2 : `CMCC_CMD_TEST3;
      tp = (t == 0) ? `CMCC_PAT1 : (t == 1) ? `CMCC_PAT2 : `CMCC_PAT3;
      cmd(tc, 0);
      wait_idle;
      for (int i = 0; i < 6; i++) pack(3 * i, tp, tp);
      cmd(`CMCC_CMD_RDCV, 19);
      chk_rd(18);
    end
    $display("test temperature and self test done");
    hm.hold_high(WDT * 50 + 2000);
    for (int i = 0; i < 6; i++) cfg[i] = (i == 0) ? `CMCC_CFG0_RST : `CMCC_CFGN_RST;
    rdcfg;
    chk(16'(stby), 16'h0001);
    $display("test watchdog done");
    end_sim;
  end
endmodule // cell_monitor_command_core_tb_top
bind cmcc_core cmcc_core_monitor #(.CELLS(CELLS), .CONV_CYC(CONV_CYC), .WDT_CYC(WDT_CYC)) u_mon (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in), .link_sel_n_in(link_sel_n_in),
  .link_mosi_in(link_mosi_in), .link_miso_oe_out(link_miso_oe_out), .over_thresh_out(over_thresh_out),
  .under_thresh_out(under_thresh_out), .comparator_duty_cycle_out(comparator_duty_cycle_out),
  .standby_out(standby_out), .toggle_poll_out(toggle_poll_out), .gpio_drive_out(gpio_drive_out),
  .conv_busy_out(conv_busy_out), .cell_discharge_control_out(cell_discharge_control_out));
`default_nettype wire
